// >>> hw/lat_table_pkg.sv
// Constants for the DDR and SDR latency parameter tables
package lat_table_pkg;

   // ==========================================================
   // Widths
   localparam int OFS_W  = 8;
   localparam int BYTE_W = 8;
   localparam int CODE_W = 2;

   // ==========================================================
   // Common values
   localparam logic [7:0] NOT_SUPP      = 8'hFF;
   localparam logic [7:0] RESET_DATA    = 8'h00;

   // ==========================================================
   // DDR latency code table: header
   localparam logic [7:0] DDR_OFS_ID    = 8'h00;
   localparam logic [7:0] DDR_OFS_LEN   = 8'h01;
   localparam logic [7:0] DDR_OFS_ROWS  = 8'h02;
   localparam logic [7:0] DDR_OFS_RLEN  = 8'h03;
   localparam logic [7:0] DDR_OFS_HDR_F = 8'h04;
   localparam logic [7:0] DDR_OFS_HDR_C = 8'h05;
   localparam logic [7:0] DDR_OFS_FR3   = 8'h06;
   localparam logic [7:0] DDR_OFS_FR4   = 8'h07;
   localparam logic [7:0] DDR_OFS_DIO3  = 8'h08;
   localparam logic [7:0] DDR_OFS_DIO4  = 8'h09;
   localparam logic [7:0] DDR_OFS_QIO3  = 8'h0A;
   localparam logic [7:0] DDR_OFS_QIO4  = 8'h0B;
   localparam logic [7:0] DDR_OFS_LAST  = 8'h2B;

   localparam logic [7:0] DDR_ID        = 8'h9A;
   localparam logic [7:0] DDR_LEN       = 8'h2A;
   localparam logic [7:0] DDR_ROWS      = 8'h05;
   localparam logic [7:0] DDR_ROW_LEN   = 8'h08;
   localparam logic [7:0] HDR_ASCII_F   = 8'h46;
   localparam logic [7:0] HDR_ASCII_C   = 8'h43;
   localparam logic [7:0] QIO_DDR_OP3   = 8'hED;
   localparam logic [7:0] QIO_DDR_OP4   = 8'hEE;

   // ==========================================================
   // DDR table: 50 MHz row
   localparam logic [7:0] DDR_OFS_R2_FREQ = 8'h0C;
   localparam logic [7:0] DDR_OFS_R2_CODE = 8'h0D;
   localparam logic [7:0] DDR_OFS_R2_MODE = 8'h12;
   localparam logic [7:0] DDR_OFS_R2_LAT  = 8'h13;
   localparam logic [7:0] R2_FREQ         = 8'h32;
   localparam logic [7:0] R2_CODE         = 8'h03;
   localparam logic [7:0] R2_MODE         = 8'h01;
   localparam logic [7:0] R2_LAT          = 8'h03;

   // ==========================================================
   // DDR table: 80 MHz row
   localparam logic [7:0] DDR_OFS_R3_FREQ = 8'h14;
   localparam logic [7:0] DDR_OFS_R3_CODE = 8'h15;
   localparam logic [7:0] DDR_OFS_R3_MODE = 8'h1A;
   localparam logic [7:0] DDR_OFS_R3_LAT  = 8'h1B;
   localparam logic [7:0] R3_FREQ         = 8'h50;
   localparam logic [7:0] R3_CODE         = 8'h00;
   localparam logic [7:0] R3_MODE         = 8'h01;
   localparam logic [7:0] R3_LAT          = 8'h06;

   // ==========================================================
   // Latency codes as programmed by the host
   localparam logic [1:0] CODE_50MHZ = 2'h3;
   localparam logic [1:0] CODE_80MHZ = 2'h0;

   // ==========================================================
   // SDR table: last row (133 MHz)
   localparam logic [7:0] SDR_OFS_R6_FREQ  = 8'h4A;
   localparam logic [7:0] SDR_OFS_R6_CODE  = 8'h4B;
   localparam logic [7:0] SDR_OFS_R6_FMODE = 8'h4E;
   localparam logic [7:0] SDR_OFS_R6_FLAT  = 8'h4F;
   localparam logic [7:0] SDR_OFS_R6_LAST  = 8'h57;
   localparam logic [7:0] SDR_R6_FREQ      = 8'h85;
   localparam logic [7:0] SDR_R6_CODE      = 8'h02;
   localparam logic [7:0] SDR_R6_FMODE     = 8'h00;
   localparam logic [7:0] SDR_R6_FLAT      = 8'h08;

   // ==========================================================
   // Table select
   typedef enum logic [0:0] {
      SEL_DDR = 1'b0,
      SEL_SDR = 1'b1
   } table_sel_t;

endpackage

// >>> hw/lat_table.sv
// Read-only latency parameter tables with a quad DDR latency lookup
`timescale 1ns/1ps
module lat_table
   import lat_table_pkg::*;
(
   input  wire logic                              i_ref_clk,
   input  wire logic                              i_sys_rst,
   input  wire logic                              i_clk_en,
   input  wire logic                              i_rd_req,
   input  wire lat_table_pkg::table_sel_t         i_rd_sel,
   input  wire logic [lat_table_pkg::OFS_W-1:0]   i_rd_ofs,
   input  wire logic [lat_table_pkg::CODE_W-1:0]  i_lat_code,
   output logic      [lat_table_pkg::BYTE_W-1:0]  o_rd_data,
   output logic                                   o_rd_valid,
   output logic      [lat_table_pkg::BYTE_W-1:0]  o_qio_mode_cycles,
   output logic      [lat_table_pkg::BYTE_W-1:0]  o_qio_dummy_cycles,
   output logic                                   o_qio_supported
);
   import lat_table_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [BYTE_W-1:0] rd_data;
      logic              rd_valid;
      logic [BYTE_W-1:0] mode;
      logic [BYTE_W-1:0] dummy;
      logic              supp;
   } state_t;

   state_t st_reg;
   state_t st_next;

   // ==========================================================
   // DDR latency code table contents
   function automatic logic [BYTE_W-1:0] ddr_byte(input logic [OFS_W-1:0] ofs);
      logic [BYTE_W-1:0] b;
      b = NOT_SUPP;
      unique case (ofs)
         DDR_OFS_ID:      b = DDR_ID;
         DDR_OFS_LEN:     b = DDR_LEN;
         DDR_OFS_ROWS:    b = DDR_ROWS;
         DDR_OFS_RLEN:    b = DDR_ROW_LEN;
         DDR_OFS_HDR_F:   b = HDR_ASCII_F;
         DDR_OFS_HDR_C:   b = HDR_ASCII_C;
         DDR_OFS_FR3:     b = NOT_SUPP;
         DDR_OFS_FR4:     b = NOT_SUPP;
         DDR_OFS_DIO3:    b = NOT_SUPP;
         DDR_OFS_DIO4:    b = NOT_SUPP;
         DDR_OFS_QIO3:    b = QIO_DDR_OP3;
         DDR_OFS_QIO4:    b = QIO_DDR_OP4;
         DDR_OFS_R2_FREQ: b = R2_FREQ;
         DDR_OFS_R2_CODE: b = R2_CODE;
         DDR_OFS_R2_MODE: b = R2_MODE;
         DDR_OFS_R2_LAT:  b = R2_LAT;
         DDR_OFS_R3_FREQ: b = R3_FREQ;
         DDR_OFS_R3_CODE: b = R3_CODE;
         DDR_OFS_R3_MODE: b = R3_MODE;
         DDR_OFS_R3_LAT:  b = R3_LAT;
         default:         b = NOT_SUPP;
      endcase
      return b;
   endfunction

   // ==========================================================
   // SDR table last row; earlier rows lie outside this block
   function automatic logic [BYTE_W-1:0] sdr_byte(input logic [OFS_W-1:0] ofs);
      logic [BYTE_W-1:0] b;
      b = NOT_SUPP;
      unique case (ofs)
         SDR_OFS_R6_FREQ:  b = SDR_R6_FREQ;
         SDR_OFS_R6_CODE:  b = SDR_R6_CODE;
         SDR_OFS_R6_FMODE: b = SDR_R6_FMODE;
         SDR_OFS_R6_FLAT:  b = SDR_R6_FLAT;
         default:          b = NOT_SUPP;
      endcase
      return b;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      st_next          = st_reg;
      st_next.rd_valid = 1'b0;
      if (i_rd_req) begin
         st_next.rd_valid = 1'b1;
         if (i_rd_sel == SEL_DDR) begin
            st_next.rd_data = ddr_byte(i_rd_ofs);
         end else begin
            st_next.rd_data = sdr_byte(i_rd_ofs);
         end
      end
      // Quad I/O DDR cycle counts for the latency code in force
      unique case (i_lat_code)
         CODE_50MHZ: begin
            st_next.mode  = R2_MODE;
            st_next.dummy = R2_LAT;
            st_next.supp  = 1'b1;
         end
         CODE_80MHZ: begin
            st_next.mode  = R3_MODE;
            st_next.dummy = R3_LAT;
            st_next.supp  = 1'b1;
         end
         default: begin
            st_next.mode  = NOT_SUPP;
            st_next.dummy = NOT_SUPP;
            st_next.supp  = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_reg <= '{rd_data: RESET_DATA, rd_valid: 1'b0,
                     mode: NOT_SUPP, dummy: NOT_SUPP, supp: 1'b0};
      end else if (i_clk_en) begin
         st_reg <= st_next;
      end
   end

   assign o_rd_data          = st_reg.rd_data;
   assign o_rd_valid         = st_reg.rd_valid;
   assign o_qio_mode_cycles  = st_reg.mode;
   assign o_qio_dummy_cycles = st_reg.dummy;
   assign o_qio_supported    = st_reg.supp;

endmodule

// >>> bench/lat_table_monitor.sv
// Checker for the latency table read and lookup ports
`timescale 1ns/1ps
module lat_table_monitor
   import lat_table_pkg::*;
(
   input wire logic                      i_ref_clk,
   input wire logic                      i_sys_rst,
   input wire logic                      i_clk_en,
   input wire logic                      i_rd_req,
   input wire lat_table_pkg::table_sel_t i_rd_sel,
   input wire logic [7:0]                i_rd_ofs,
   input wire logic [1:0]                i_lat_code,
   input wire logic [7:0]                o_rd_data,
   input wire logic                      o_rd_valid,
   input wire logic [7:0]                o_qio_mode_cycles,
   input wire logic [7:0]                o_qio_dummy_cycles,
   input wire logic                      o_qio_supported
);
   logic go;
   assign go = i_clk_en && i_rd_req;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   chk_valid_pulse: assert property (go |=> o_rd_valid) else $error("read lost");
   chk_valid_idle: assert property (i_clk_en && !i_rd_req |=> !o_rd_valid)
      else $error("stray valid");
   chk_hold_frozen: assert property (!i_clk_en |=> $stable(o_rd_data) && $stable(o_rd_valid))
      else $error("moved while disabled");
   chk_table_id: assert property (go && i_rd_sel == SEL_DDR && i_rd_ofs == 8'h00 |=>
      o_rd_data == 8'h9A) else $error("bad id");
   chk_table_len: assert property (go && i_rd_sel == SEL_DDR && i_rd_ofs == 8'h01 |=>
      o_rd_data == 8'h2A) else $error("bad length");
   chk_quad_ops: assert property (go && i_rd_sel == SEL_DDR && i_rd_ofs[7:1] == 7'h05 |=>
      o_rd_data == (($past(i_rd_ofs) == 8'h0B) ? 8'hEE : 8'hED)) else $error("bad opcode");
   chk_sdr_tail: assert property (go && i_rd_sel == SEL_SDR && i_rd_ofs inside {[8'h51:8'h57]}
      |=> o_rd_data == 8'hFF) else $error("bad sdr tail");
   chk_slow_code: assert property (i_clk_en && i_lat_code == 2'h3 |=> o_qio_supported &&
      o_qio_mode_cycles == 8'h01 && o_qio_dummy_cycles == 8'h03) else $error("bad 50 MHz");
   chk_fast_code: assert property (i_clk_en && i_lat_code == 2'h0 |=> o_qio_supported &&
      o_qio_mode_cycles == 8'h01 && o_qio_dummy_cycles == 8'h06) else $error("bad 80 MHz");
   chk_no_code: assert property (i_clk_en && i_lat_code inside {2'h1, 2'h2} |=>
      !o_qio_supported && o_qio_mode_cycles == 8'hFF && o_qio_dummy_cycles == 8'hFF)
      else $error("bad unsupported code");
endmodule
bind lat_table lat_table_monitor u_lat_table_monitor (.i_ref_clk, .i_sys_rst, .i_clk_en,
   .i_rd_req, .i_rd_sel, .i_rd_ofs, .i_lat_code, .o_rd_data, .o_rd_valid,
   .o_qio_mode_cycles, .o_qio_dummy_cycles, .o_qio_supported);

// >>> bench/lat_host.sv
// Host model that reads table bytes and programs the latency code
`timescale 1ns/1ps
module lat_host
   import lat_table_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic [7:0]        i_data,
   input  wire logic              i_valid,
   output logic                   o_req,
   output lat_table_pkg::table_sel_t o_sel,
   output logic [7:0]             o_ofs,
   output logic [1:0]             o_code
);
   initial begin
      o_req = 1'b0;
      o_sel = SEL_DDR;
      o_ofs = 8'h00;
      o_code = 2'h1;
   end
   // Called just after an edge; request stays up for back-to-back reads
   task rd(input table_sel_t s, input logic [7:0] a, output logic v, output logic [7:0] d);
      o_req = 1'b1;
      o_sel = s;
      o_ofs = a;
      @(posedge i_ref_clk);
      #1;
      v = i_valid;
      d = i_data;
   endtask
   // Released offset lines show a changed pattern, not the last value
   task idle;
      o_req = 1'b0;
      o_ofs = ~o_ofs;
      @(posedge i_ref_clk);
      #1;
   endtask
   task setc(input logic [1:0] c);
      o_code = c;
      idle;
   endtask
   task next_param(output logic [7:0] n);
      logic v;
      logic [7:0] len;
      rd(SEL_DDR, 8'h01, v, len);
      n = 8'h01 + len + 8'h01;
      idle;
   endtask
   task pick(input logic [7:0] mhz, output logic [1:0] c);
      logic v;
      logic [7:0] f;
      logic [7:0] k;
      rd(SEL_DDR, 8'h0C, v, f);
      rd(SEL_DDR, (f >= mhz) ? 8'h0D : 8'h15, v, k);
      c = k[1:0];
      setc(c);
   endtask
endmodule

// >>> bench/tb.sv
// Testbench for the latency parameter table block
`timescale 1ns/1ps
module tb;
   import lat_table_pkg::*;
   localparam logic [0:43][7:0] DDR_EXP = {
      8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hED, 8'hEE,
      8'h32, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h03, 8'h50, 8'h00, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'h01, 8'h06, {16{8'hFF}}};
   localparam logic [0:13][7:0] SDR_EXP = {8'h85, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'h08, {8{8'hFF}}};
   logic       ref_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       clk_en = 1'b1;
   logic       rd_req, rd_valid, supp, v;
   table_sel_t rd_sel;
   logic [7:0] rd_ofs, rd_data, mode_cyc, dummy_cyc, d;
   logic [1:0] lat_code, c;
   int         num_errors = 0;
   int         checks = 0;
   int         cycles = 0;
   lat_table u_lat_table (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_clk_en(clk_en),
      .i_rd_req(rd_req), .i_rd_sel(rd_sel), .i_rd_ofs(rd_ofs), .i_lat_code(lat_code),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_qio_mode_cycles(mode_cyc),
      .o_qio_dummy_cycles(dummy_cyc), .o_qio_supported(supp));
   lat_host u_lat_host (.i_ref_clk(ref_clk), .i_data(rd_data), .i_valid(rd_valid),
      .o_req(rd_req), .o_sel(rd_sel), .o_ofs(rd_ofs), .o_code(lat_code));
   always #5 ref_clk = ~ref_clk;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      if (num_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task t_tables;
      for (int a = 0; a < 48; a++) begin
         u_lat_host.rd(SEL_DDR, 8'(a), v, d);
         chk({7'h0, v}, 8'h01);
         chk(d, (a < 44) ? DDR_EXP[a] : 8'hFF);
      end
      for (int a = 8'h48; a < 8'h5A; a++) begin
         u_lat_host.rd(SEL_SDR, 8'(a), v, d);
         chk(d, (a >= 8'h4A && a <= 8'h57) ? SDR_EXP[a - 8'h4A] : 8'hFF);
      end
      u_lat_host.idle;
      chk({7'h0, rd_valid}, 8'h00);
   endtask
   task t_lookup;
      u_lat_host.pick(8'd50, c);
      chk({6'h0, c}, 8'h03);
      chk({mode_cyc, dummy_cyc, 7'h0, supp}, 24'h010301);
      u_lat_host.pick(8'd80, c);
      chk({6'h0, c}, 8'h00);
      chk({mode_cyc, dummy_cyc, 7'h0, supp}, 24'h010601);
      for (int k = 1; k < 3; k++) begin
         u_lat_host.setc(2'(k));
         chk({mode_cyc, dummy_cyc, 7'h0, supp}, 24'hFFFF00);
      end
      u_lat_host.next_param(d);
      chk(d, 8'h2C);
   endtask
   task t_freeze;
      u_lat_host.rd(SEL_DDR, 8'h00, v, d);
      clk_en = 1'b0;
      u_lat_host.rd(SEL_DDR, 8'h01, v, d);
      chk({v, 7'h0}, 8'h80);
      chk(d, 8'h9A);
      clk_en = 1'b1;
      u_lat_host.rd(SEL_DDR, 8'h01, v, d);
      chk(d, 8'h2A);
      u_lat_host.idle;
      chk({7'h0, rd_valid}, 8'h00);
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         print_verdict;
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      t_tables;
      t_lookup;
      t_freeze;
      print_verdict;
   end
endmodule
